/* File: rtl/fibre_ring_io_pkg.sv */
package fibre_ring_io_pkg;

  // Port organisation
  localparam int NUM_PORTS = 4;
  localparam int PORT_W    = 8;
  localparam int POINTS    = NUM_PORTS * PORT_W;
  localparam int NUM_PAIRS = 2;
  localparam int NUM_FAST  = 4;

  // Timing
  localparam int CLK_PERIOD_NS = 8;
  localparam int WD_TIME_NS    = 100_000_000;
  localparam int WD_CYCLES     = WD_TIME_NS / CLK_PERIOD_NS;
  localparam int WD_CNT_W      = 24;
  localparam int LATCH_TIME_NS = 6_800_000;
  localparam int LATCH_CYCLES  = LATCH_TIME_NS / CLK_PERIOD_NS;
  localparam int LATCH_CNT_W   = 20;
  localparam int BAUD_RATE     = 2_500_000;
  localparam int BIT_TIME_NS   = 1_000_000_000 / BAUD_RATE;
  localparam int BIT_CYCLES    = BIT_TIME_NS / CLK_PERIOD_NS;
  localparam int PAYLOAD_BITS  = 32;
  localparam int FRAME_MARGIN  = 2;
  localparam int FRAME_LIMIT   = FRAME_MARGIN * PAYLOAD_BITS * BIT_CYCLES;
  localparam int FRAME_CNT_W   = 12;
  localparam int GOOD_RUN_CLEAR = 3;

  // Register map
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] REG_NODE_ADDR = 12'h000;
  localparam logic [ADDR_W-1:0] REG_STATE     = 12'h004;
  localparam logic [ADDR_W-1:0] REG_STATUS    = 12'h008;
  localparam logic [ADDR_W-1:0] REG_MASK      = 12'h00C;
  localparam logic [ADDR_W-1:0] REG_OUT_IMAGE = 12'h010;
  localparam logic [ADDR_W-1:0] REG_IN_IMAGE  = 12'h014;
  localparam logic [7:0]        NODE_ADDR_RST = 8'h00;

  // Event bits, shared by status and mask
  localparam int EVT_W       = 4;
  localparam int EVT_GOOD    = 0;
  localparam int EVT_BAD     = 1;
  localparam int EVT_WD_TOUT = 2;
  localparam int EVT_FAST    = 3;

  // State register fields
  localparam int ST_CYCLE    = 0;
  localparam int ST_ERROR    = 1;
  localparam int ST_WATCHDOG = 2;
  localparam int ST_DIR_LSB  = 4;
  localparam int ST_WDJ_LSB  = 8;
  localparam int ST_LATCH    = 10;
  localparam int ST_FASTJ_LSB = 12;

  typedef struct packed {
    logic        write;
    logic [7:0]  addr;
    logic [31:0] data;
    logic        csum_ok;
    logic        frame_ok;
  } telegram_s;

  typedef enum logic [1:0] {
    LINK_IDLE  = 2'b01,
    LINK_FRAME = 2'b10
  } link_state_e;

endpackage

/* File: rtl/fibre_ring_io_node.sv */
`timescale 1ns/100ps
module fibre_ring_io_node
  import fibre_ring_io_pkg::*;
#(
  parameter int unsigned WD_CYCLES_P    = WD_CYCLES,
  parameter int unsigned LATCH_CYCLES_P = LATCH_CYCLES
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              rx_start,
  input  wire logic              rx_stop,
  input  wire logic              rx_done,
  input  wire telegram_s         rx_tlg,
  output logic      [31:0]       tx_data,
  output logic                   tx_valid,
  input  wire logic [NUM_PORTS-1:0] dir_switch,
  input  wire logic [NUM_PAIRS-1:0] wd_disable_jumper,
  input  wire logic              latch_jumper,
  input  wire logic [NUM_FAST-1:0]  fast_irq_jumper,
  input  wire logic [POINTS-1:0] point_in,
  output logic      [POINTS-1:0] point_out,
  output logic      [POINTS-1:0] point_oe,
  output logic      [POINTS-1:0] point_led,
  output logic                   cycle_indicator,
  output logic                   error_indicator,
  output logic                   watchdog_indicator,
  output logic      [NUM_FAST-1:0] fast_irq_input,
  output logic                   irq
);

  localparam logic [WD_CNT_W-1:0]    WD_LAST    = WD_CNT_W'(WD_CYCLES_P - 1);
  localparam logic [LATCH_CNT_W-1:0] LATCH_LAST = LATCH_CNT_W'(LATCH_CYCLES_P - 1);
  localparam logic [FRAME_CNT_W-1:0] FRAME_LAST = FRAME_CNT_W'(FRAME_LIMIT - 1);
  localparam logic [1:0]             GOOD_LAST  = 2'(GOOD_RUN_CLEAR - 1);

  logic [7:0]             node_addr_r;
  logic [EVT_W-1:0]       mask_r;
  logic [EVT_W-1:0]       status_r;
  logic [EVT_W-1:0]       status_nxt;
  logic [EVT_W-1:0]       events;
  logic [31:0]            prdata_r;
  logic                   pready_r;
  logic                   pslverr_r;
  logic                   irq_r;
  link_state_e            link_state_r;
  logic [FRAME_CNT_W-1:0] frame_cnt_r;
  logic                   cycle_r;
  logic                   error_r;
  logic [1:0]             good_run_r;
  logic                   wd_r;
  logic [WD_CNT_W-1:0]    wd_cnt_r;
  logic [LATCH_CNT_W-1:0] latch_cnt_r;
  logic [POINTS-1:0]      in_latched_r;
  logic [NUM_PORTS-1:0]   dir_r;
  logic [PORT_W-1:0]      out_byte_r [NUM_PORTS];
  logic [PORT_W-1:0]      led_byte_r [NUM_PORTS];
  logic [31:0]            reply;
  logic [31:0]            tx_data_r;
  logic                   tx_valid_r;
  logic [NUM_FAST-1:0]    fast_r;
  logic [NUM_FAST-1:0]    fast_nxt;
  logic [31:0]            read_mux;
  logic [31:0]            state_word;
  logic                   addr_hit;
  logic                   apb_setup;
  logic                   apb_done;
  logic                   frame_timeout;
  logic                   addr_match;
  logic                   tlg_good;
  logic                   tlg_bad;
  logic                   good_write;
  logic                   wd_timeout;
  logic                   latch_tick;
  logic [NUM_PAIRS-1:0]   kill_pair;

  // Telegram classification
  // A frame with no stop bit in time counts as a framing error
  assign frame_timeout = (link_state_r == LINK_FRAME) && (frame_cnt_r == FRAME_LAST);
  assign addr_match    = (rx_tlg.addr == node_addr_r);
  assign tlg_good      = rx_done & rx_tlg.csum_ok & rx_tlg.frame_ok;
  assign tlg_bad       = (rx_done & ~(rx_tlg.csum_ok & rx_tlg.frame_ok))
                         | frame_timeout;
  assign good_write    = tlg_good & rx_tlg.write & addr_match;
  assign wd_timeout    = wd_r && (wd_cnt_r == WD_LAST);
  assign latch_tick    = (latch_cnt_r == LATCH_LAST);

  // Jumpered pairs keep their outputs through errors and timeouts
  // The watchdog indicator still drops for a jumpered pair
  always_comb begin
    for (int k = 0; k < NUM_PAIRS; k++) begin
      kill_pair[k] = (tlg_bad | wd_timeout) & ~wd_disable_jumper[k];
    end
  end

  // Link framing and cycle indicator
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_state_r <= LINK_IDLE;
      frame_cnt_r  <= '0;
      cycle_r      <= 1'b0;
    end else begin
      case (link_state_r)
        LINK_IDLE: begin
          frame_cnt_r <= '0;
          if (rx_start) begin
            link_state_r <= LINK_FRAME;
            cycle_r      <= 1'b1;
          end
        end
        LINK_FRAME: begin
          // A lost stop bit must not hang the cycle indicator
          if (rx_start) begin
            frame_cnt_r <= '0;
          end else if (rx_stop || frame_timeout) begin
            link_state_r <= LINK_IDLE;
            cycle_r      <= 1'b0;
          end else begin
            frame_cnt_r <= frame_cnt_r + 1'b1;
          end
        end
        default: begin
          link_state_r <= LINK_IDLE;
          cycle_r      <= 1'b0;
        end
      endcase
    end
  end

  // Error indicator with good-telegram run counter
  // Any bad telegram restarts the run, addressed or not
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      error_r    <= 1'b0;
      good_run_r <= 2'h0;
    end else if (tlg_bad) begin
      error_r    <= 1'b1;
      good_run_r <= 2'h0;
    end else if (tlg_good && error_r) begin
      if (good_run_r == GOOD_LAST) begin
        error_r    <= 1'b0;
        good_run_r <= 2'h0;
      end else begin
        good_run_r <= good_run_r + 2'h1;
      end
    end
  end

  // Watchdog
  // Counts only after a first good write; outputs start off anyway
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_r     <= 1'b0;
      wd_cnt_r <= '0;
    end else if (good_write) begin
      wd_r     <= 1'b1;
      wd_cnt_r <= '0;
    end else if (wd_timeout) begin
      wd_r     <= 1'b0;
      wd_cnt_r <= '0;
    end else if (wd_r) begin
      wd_cnt_r <= wd_cnt_r + 1'b1;
    end
  end

  // Input latch
  // Free-running period, so the first sample after a change may lag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch_cnt_r  <= '0;
      in_latched_r <= '0;
    end else begin
      latch_cnt_r <= latch_tick ? '0 : latch_cnt_r + 1'b1;
      if (!latch_jumper || latch_tick) begin
        in_latched_r <= point_in;
      end
    end
  end

  // Per-port direction, output byte, indicator and reply byte
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    logic [PORT_W-1:0] state_byte;

    assign state_byte = dir_r[p] ? out_byte_r[p] : in_latched_r[PORT_W*p +: PORT_W];
    assign reply[PORT_W*p +: PORT_W] = state_byte;

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        dir_r[p] <= 1'b0;
      end else begin
        dir_r[p] <= dir_switch[p];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        out_byte_r[p] <= '0;
      end else if (!dir_r[p] || !dir_switch[p]) begin
        // Cleared with the switch so no value outlives its output enable
        out_byte_r[p] <= '0;
      end else if (good_write) begin
        out_byte_r[p] <= rx_tlg.data[PORT_W*p +: PORT_W];
      end else if (kill_pair[p/2]) begin
        out_byte_r[p] <= '0;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        led_byte_r[p] <= '0;
      end else begin
        led_byte_r[p] <= state_byte;
      end
    end

    assign point_out[PORT_W*p +: PORT_W] = out_byte_r[p];
    assign point_oe[PORT_W*p +: PORT_W]  = {PORT_W{dir_r[p]}};
    assign point_led[PORT_W*p +: PORT_W] = led_byte_r[p];
  end

  // Fast inputs bypass the latch so interrupts are not delayed by it
  always_comb begin
    for (int i = 0; i < NUM_FAST; i++) begin
      fast_nxt[i] = fast_irq_jumper[i]
                    & (dir_r[0] ? out_byte_r[0][i] : point_in[i]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fast_r <= '0;
    end else begin
      fast_r <= fast_nxt;
    end
  end

  // Reply telegram toward the ring
  // Output bytes return the value held before the write in this telegram
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_data_r  <= '0;
      tx_valid_r <= 1'b0;
    end else begin
      tx_valid_r <= tlg_good & addr_match;
      if (tlg_good && addr_match) begin
        tx_data_r <= reply;
      end
    end
  end

  // Interrupt status: set wins over the read clear
  always_comb begin
    events              = '0;
    events[EVT_GOOD]    = tlg_good;
    events[EVT_BAD]     = tlg_bad;
    events[EVT_WD_TOUT] = wd_timeout;
    events[EVT_FAST]    = |(fast_nxt & ~fast_r);
    status_nxt          = status_r | events;
    // Only bits actually returned to software are cleared
    if (apb_done && !pwrite && paddr == REG_STATUS) begin
      status_nxt = (status_r & ~prdata_r[EVT_W-1:0]) | events;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= '0;
      irq_r    <= 1'b0;
    end else begin
      status_r <= status_nxt;
      irq_r    <= |(status_nxt & mask_r);
    end
  end

  // APB slave, no wait states
  // Read data captured at setup, so clear-on-read drops only what was returned
  assign apb_setup = psel & ~penable;
  assign apb_done  = psel & penable & pready_r;

  always_comb begin
    state_word                                  = '0;
    state_word[ST_CYCLE]                        = cycle_r;
    state_word[ST_ERROR]                        = error_r;
    state_word[ST_WATCHDOG]                     = wd_r;
    state_word[ST_DIR_LSB +: NUM_PORTS]         = dir_r;
    state_word[ST_WDJ_LSB +: NUM_PAIRS]         = wd_disable_jumper;
    state_word[ST_LATCH]                        = latch_jumper;
    state_word[ST_FASTJ_LSB +: NUM_FAST]        = fast_irq_jumper;
  end

  always_comb begin
    addr_hit = 1'b1;
    read_mux = '0;
    case (paddr)
      REG_NODE_ADDR: read_mux = {24'h000000, node_addr_r};
      REG_STATE:     read_mux = state_word;
      REG_STATUS:    read_mux = {{(32-EVT_W){1'b0}}, status_r};
      REG_MASK:      read_mux = {{(32-EVT_W){1'b0}}, mask_r};
      REG_OUT_IMAGE: read_mux = point_out;
      REG_IN_IMAGE:  read_mux = in_latched_r;
      default:       addr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= '0;
    end else begin
      pready_r  <= apb_setup;
      pslverr_r <= apb_setup & ~addr_hit;
      if (apb_setup) begin
        prdata_r <= pwrite ? 32'h00000000 : read_mux;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      node_addr_r <= NODE_ADDR_RST;
      mask_r      <= '0;
    end else if (apb_done && pwrite) begin
      if (paddr == REG_NODE_ADDR) begin
        node_addr_r <= pwdata[7:0];
      end
      if (paddr == REG_MASK) begin
        mask_r <= pwdata[EVT_W-1:0];
      end
    end
  end

  assign prdata             = prdata_r;
  assign pready             = pready_r;
  assign pslverr            = pslverr_r;
  assign tx_data            = tx_data_r;
  assign tx_valid           = tx_valid_r;
  assign cycle_indicator    = cycle_r;
  assign error_indicator    = error_r;
  assign watchdog_indicator = wd_r;
  assign fast_irq_input     = fast_r;
  assign irq                = irq_r;

endmodule // fibre_ring_io_node

/* File: testbench/fibre_ring_io_props.sv */
`timescale 1ns/100ps
module fibre_ring_io_props
  import fibre_ring_io_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pready,
  input wire logic              rx_start,
  input wire logic              rx_stop,
  input wire logic              rx_done,
  input wire telegram_s         rx_tlg,
  input wire logic              tx_valid,
  input wire logic [NUM_PAIRS-1:0] wd_disable_jumper,
  input wire logic [POINTS-1:0] point_out,
  input wire logic [POINTS-1:0] point_oe,
  input wire logic              cycle_indicator,
  input wire logic              error_indicator,
  input wire logic              watchdog_indicator
);
  wire tlg_good = rx_tlg.csum_ok && rx_tlg.frame_ok;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_cyc_on; rx_start |=> cycle_indicator; endproperty
  a_cyc_on: assert property (p_cyc_on) else $error("cycle indicator not set");
  property p_cyc_off; rx_stop && !rx_start |=> !cycle_indicator; endproperty
  a_cyc_off: assert property (p_cyc_off) else $error("cycle indicator not cleared");
  property p_err_set; rx_done && !tlg_good |=> error_indicator; endproperty
  a_err_set: assert property (p_err_set) else $error("error indicator not set");
  property p_err_hold; error_indicator && !rx_done |=> error_indicator; endproperty
  a_err_hold: assert property (p_err_hold) else $error("error cleared without telegram");
  property p_wd_on; rx_done && tlg_good && rx_tlg.write ##1 tx_valid |-> watchdog_indicator;
  endproperty
  a_wd_on: assert property (p_wd_on) else $error("watchdog indicator not set");
  property p_err_off; rx_done && !tlg_good && wd_disable_jumper == 2'b00 |=> point_out == '0;
  endproperty
  a_err_off: assert property (p_err_off) else $error("outputs kept after error");
  property p_keep01;
    rx_done && !tlg_good && wd_disable_jumper[0] |=> $stable(point_out[15:0]);
  endproperty
  a_keep01: assert property (p_keep01) else $error("ports 0,1 dropped");
  property p_keep23;
    rx_done && !tlg_good && wd_disable_jumper[1] |=> $stable(point_out[31:16]);
  endproperty
  a_keep23: assert property (p_keep23) else $error("ports 2,3 dropped");
  property p_in_off; (point_out & ~point_oe) == '0; endproperty
  a_in_off: assert property (p_in_off) else $error("input port drives output");
  property p_apb; psel && !penable |=> pready; endproperty
  a_apb: assert property (p_apb) else $error("no ready after setup");
endmodule // fibre_ring_io_props
bind fibre_ring_io_node fibre_ring_io_props u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .rx_start(rx_start), .rx_stop(rx_stop),
  .rx_done(rx_done), .rx_tlg(rx_tlg), .tx_valid(tx_valid), .point_out(point_out),
  .wd_disable_jumper(wd_disable_jumper), .point_oe(point_oe),
  .cycle_indicator(cycle_indicator), .error_indicator(error_indicator),
  .watchdog_indicator(watchdog_indicator));

/* File: testbench/fibre_ring_master.sv */
`timescale 1ns/100ps
module fibre_ring_master
  import fibre_ring_io_pkg::*;
(
  input  wire logic pclk,
  output logic      rx_start,
  output logic      rx_stop,
  output logic      rx_done,
  output telegram_s rx_tlg
);
  // Four-cycle frame gap keeps runs brief; the node only times out a frame that outlasts FRAME_LIMIT
  localparam int FRAME_GAP = 4;
  initial begin
    rx_start = 1'b0;
    rx_stop  = 1'b0;
    rx_done  = 1'b0;
    rx_tlg   = '0;
  end
  task automatic send(input logic wr, input logic [7:0] adr, input logic [31:0] dat,
                      input logic ck, input logic fr);
    @(posedge pclk);
    rx_start <= 1'b1;
    @(posedge pclk);
    rx_start <= 1'b0;
    repeat (FRAME_GAP) @(posedge pclk);
    rx_stop <= 1'b1;
    @(posedge pclk);
    rx_stop <= 1'b0;
    rx_done <= 1'b1;
    rx_tlg  <= '{write: wr, addr: adr, data: dat, csum_ok: ck, frame_ok: fr};
    @(posedge pclk);
    rx_done <= 1'b0;
    // Released fields inverted so stale data never matches the telegram just sent
    rx_tlg  <= '{write: ~wr, addr: ~adr, data: ~dat, csum_ok: ~ck, frame_ok: ~fr};
  endtask
endmodule // fibre_ring_master

/* File: testbench/fibre_ring_io_node_bench.sv */
`timescale 1ns/100ps
module fibre_ring_io_node_bench
  import fibre_ring_io_pkg::*;
;
  localparam int WD_P = 400;
  localparam int LATCH_P = 20;
  logic              pclk, presetn, psel, penable, pwrite, latch_jumper;
  logic [ADDR_W-1:0] paddr;
  logic [31:0]       pwdata, prdata, tx_data, q, pin;
  logic              pready, pslverr, tx_valid, err, irq;
  logic              rx_start, rx_stop, rx_done;
  logic              cycle_indicator, error_indicator, watchdog_indicator;
  telegram_s         rx_tlg;
  logic [3:0]        dir_switch, fast_irq_jumper, fast_irq_input;
  logic [1:0]        wd_disable_jumper;
  logic [POINTS-1:0] point_out, point_oe, point_led;
  int                n_errors, tests_run, w;
  fibre_ring_io_node #(.WD_CYCLES_P(WD_P), .LATCH_CYCLES_P(LATCH_P)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_start(rx_start), .rx_stop(rx_stop), .rx_done(rx_done), .rx_tlg(rx_tlg),
    .tx_data(tx_data), .tx_valid(tx_valid), .dir_switch(dir_switch),
    .wd_disable_jumper(wd_disable_jumper), .latch_jumper(latch_jumper),
    .fast_irq_jumper(fast_irq_jumper), .point_in(pin), .point_out(point_out),
    .point_oe(point_oe), .point_led(point_led), .cycle_indicator(cycle_indicator),
    .error_indicator(error_indicator), .watchdog_indicator(watchdog_indicator),
    .fast_irq_input(fast_irq_input), .irq(irq));
  fibre_ring_master master (.pclk(pclk), .rx_start(rx_start), .rx_stop(rx_stop),
    .rx_done(rx_done), .rx_tlg(rx_tlg));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Called right after a rising edge; returns one idle edge after the sampling edge
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin
      n_errors++;
      tally_and_finish();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle edge so a following call never re-drives psel in this step
    @(posedge pclk);
  endtask
  initial begin
    n_errors = 0;
    tests_run = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    dir_switch = 4'b0101;
    wd_disable_jumper = 2'b00;
    latch_jumper = 1'b0;
    fast_irq_jumper = 4'h0;
    pin = 32'hA5C3_3C5A;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, REG_NODE_ADDR, 32'h0);
    chk("node_addr_rst", q, 32'h0);
    apb(1'b0, REG_MASK, 32'h0);
    chk("mask_rst", q, 32'h0);
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped", {err, q[30:0]}, 32'h8000_0000);
    apb(1'b1, REG_NODE_ADDR, 32'h5);
    apb(1'b1, REG_MASK, 32'hF);
    apb(1'b0, REG_NODE_ADDR, 32'h0);
    chk("node_addr", q, 32'h5);
    master.send(1'b1, 8'h05, 32'h1122_3344, 1'b1, 1'b1);
    @(posedge pclk);
    chk("tx_valid", tx_valid, 1'b1);
    @(posedge pclk);
    chk("out", point_out, 32'h0022_0044);
    chk("oe", point_oe, 32'h00FF_00FF);
    chk("wd_ind", watchdog_indicator, 1'b1);
    // Output bytes reply with the value held before this write
    chk("tx", tx_data, {pin[31:24], 8'h00, pin[15:8], 8'h00});
    chk("led", {point_led[31:24], point_led[7:0]}, {pin[31:24], 8'h44});
    chk("irq_on", irq, 1'b1);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status_good", q[3:0], 4'h1);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status_clr", q[3:0], 4'h0);
    repeat (2) @(posedge pclk);
    chk("irq_off", irq, 1'b0);
    fast_irq_jumper <= 4'hF;
    repeat (4) @(posedge pclk);
    chk("fast", fast_irq_input, 4'h4);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status_fast", q[3:0], 4'h8);
    apb(1'b1, REG_MASK, 32'h0);
    master.send(1'b1, 8'h06, 32'hFFFF_FFFF, 1'b1, 1'b1);
    repeat (3) @(posedge pclk);
    chk("other_addr", point_out, 32'h0022_0044);
    chk("irq_masked", irq, 1'b0);
    wd_disable_jumper <= 2'b01;
    master.send(1'b1, 8'h05, 32'h0, 1'b0, 1'b1);
    repeat (2) @(posedge pclk);
    chk("err_on", error_indicator, 1'b1);
    chk("err_out", point_out, 32'h0000_0044);
    master.send(1'b1, 8'h05, 32'h5566_7788, 1'b1, 1'b1);
    master.send(1'b1, 8'h05, 32'h5566_7788, 1'b1, 1'b1);
    repeat (2) @(posedge pclk);
    chk("restore", point_out, 32'h0066_0088);
    chk("err_two", error_indicator, 1'b1);
    master.send(1'b1, 8'h05, 32'h5566_7788, 1'b1, 1'b1);
    repeat (2) @(posedge pclk);
    chk("err_clr", error_indicator, 1'b0);
    wd_disable_jumper <= 2'b10;
    repeat (WD_P + 20) @(posedge pclk);
    chk("wd_out", point_out, 32'h0066_0000);
    chk("wd_ind_off", watchdog_indicator, 1'b0);
    apb(1'b0, REG_STATUS, 32'h0);
    chk("status_wd", q[EVT_WD_TOUT], 1'b1);
    master.send(1'b0, 8'h05, 32'h0, 1'b1, 1'b0);
    repeat (2) @(posedge pclk);
    chk("keep23", point_out, 32'h0066_0000);
    wd_disable_jumper <= 2'b00;
    master.send(1'b0, 8'h06, 32'h0, 1'b0, 1'b0);
    repeat (2) @(posedge pclk);
    chk("err_all_off", point_out, 32'h0000_0000);
    latch_jumper <= 1'b1;
    pin <= 32'h3C00_0000;
    repeat (LATCH_P + 5) @(posedge pclk);
    chk("latched", point_led[31:24], 8'h3C);
    // Find the latch phase, then show the value holds for one period
    pin <= 32'h5A00_0000;
    w = 0;
    do begin
      @(posedge pclk);
      w++;
    end while (point_led[31:24] !== 8'h5A && w < 2 * LATCH_P);
    if (w >= 2 * LATCH_P) begin
      n_errors++;
      tally_and_finish();
    end
    chk("latch_tick", point_led[31:24], 8'h5A);
    pin <= 32'h9600_0000;
    repeat (LATCH_P - 3) @(posedge pclk);
    chk("latch_hold", point_led[31:24], 8'h5A);
    repeat (5) @(posedge pclk);
    chk("latch_next", point_led[31:24], 8'h96);
    apb(1'b0, REG_IN_IMAGE, 32'h0);
    chk("in_image", q, 32'h9600_0000);
    master.send(1'b1, 8'h05, 32'h5566_7788, 1'b1, 1'b1);
    repeat (2) @(posedge pclk);
    chk("rearm", point_out, 32'h0066_0088);
    dir_switch <= 4'b1010;
    repeat (2) @(posedge pclk);
    chk("oe_swap", point_oe, 32'hFF00_FF00);
    chk("in_cleared", point_out, 32'h0000_0000);
    master.send(1'b1, 8'h05, 32'h1122_3344, 1'b1, 1'b1);
    repeat (2) @(posedge pclk);
    chk("out_swap", point_out, 32'h1100_3300);
    chk("led_out3", point_led[31:24], 8'h11);
    apb(1'b0, REG_STATE, 32'h0);
    chk("state", q, 32'h0000_F4A6);
    apb(1'b0, REG_OUT_IMAGE, 32'h0);
    chk("out_image", q, 32'h1100_3300);
    tally_and_finish();
  end
endmodule // fibre_ring_io_node_bench
